// >>> rtl/tcwc_channel.sv
// One 16-bit timer channel: capture, waveform, stepper, Avalon slave
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Mode bit picks capture or waveform
// - Chosen line A edge loads capture A/B
// - Subsample loads to 1,2,4,8,16 edges
// - A loads first or after B
// - B loads only after A
// - Reload before read flags overrun, overwrites
// - Combined read-out, DMA request per load
// - DMA path only reads from timer
// - Capture trigger picks line, edge, none
// - A, B, C compare in waveform mode
// - Profile 00 free-runs, wraps, retriggers
// - Profile 10 wraps at period compare
// - Profile 01 up/down full, trigger reverses
// - Profile 11 up/down to period, reverses
// - Period match stops or disables clock
// - Event on clocks or line B, edge
// - Event on line B frees it, mutes B
// - Event triggers only when enabled
// - Sync, software, period match trigger
// - Events set/clear/toggle lines
// - Gray stepper on both lines
// - Write protection blocks config writes
// - Trigger acts at next counter tick
module tcwc_channel
  import tcwc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CNT_TICK,
  input wire logic SYNC_IN,
  input wire logic CH0_CLK_ON,
  input wire logic CHANNEL_IO_A_IN,
  output logic CHANNEL_IO_A_OUT,
  output logic CHANNEL_IO_A_OE,
  input wire logic CHANNEL_IO_B_IN,
  output logic CHANNEL_IO_B_OUT,
  output logic CHANNEL_IO_B_OE,
  input wire logic EXTERNAL_CLOCK_0,
  input wire logic EXTERNAL_CLOCK_1,
  input wire logic EXTERNAL_CLOCK_2,
  output logic DMA_REQ
);
  // Pin synchronisers: stage 1, stage 2, delayed copy for edges
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_s3_r;
  // Bus handshake
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  // Software state
  logic [31:0] channel_mode_register_r;
  logic [1:0] stepper_mode_register_r;
  logic write_protect_enable_r;
  logic [15:0] capture_compare_a_r;
  logic [15:0] capture_compare_b_r;
  logic [15:0] period_compare_r;
  // Counter state
  logic [15:0] counter_value_r;
  logic [15:0] counter_value_nxt;
  tcwc_dir_t dir_r;
  tcwc_dir_t dir_nxt;
  logic clk_en_r;
  logic clk_run_r;
  logic trig_pend_r;
  // Capture bookkeeping
  logic [3:0] sub_cnt_r;
  logic b_ok_r;
  logic unread_a_r;
  logic unread_b_r;
  logic a_older_r;
  // Status flags, sticky until the status read
  logic covf_r;
  logic load_overrun_flag_r;
  logic ldras_r;
  logic ldrbs_r;
  // Output side
  logic [1:0] gray_cnt_r;
  logic io_a_r;
  logic io_b_r;
  logic io_a_oe_r;
  logic io_b_oe_r;
  logic io_a_nxt;
  logic io_b_nxt;
  logic dma_r;
  logic covf_set;

  // Edge pairs from the synchronised pins
  tcwc_edge_t e_a, e_b, e_x0, e_x1, e_x2, e_sel;
  assign e_a = '{rise: pin_s2_r[0] & ~pin_s3_r[0],
                 fall: ~pin_s2_r[0] & pin_s3_r[0]};
  assign e_b = '{rise: pin_s2_r[1] & ~pin_s3_r[1],
                 fall: ~pin_s2_r[1] & pin_s3_r[1]};
  assign e_x0 = '{rise: pin_s2_r[2] & ~pin_s3_r[2],
                  fall: ~pin_s2_r[2] & pin_s3_r[2]};
  assign e_x1 = '{rise: pin_s2_r[3] & ~pin_s3_r[3],
                  fall: ~pin_s2_r[3] & pin_s3_r[3]};
  assign e_x2 = '{rise: pin_s2_r[4] & ~pin_s3_r[4],
                  fall: ~pin_s2_r[4] & pin_s3_r[4]};

  // Mode fields
  wire wave = channel_mode_register_r[CMR_WAVE];
  wire [1:0] edge2 = channel_mode_register_r[CMR_EDGE2 +: 2];
  wire [1:0] first_capture_edge = channel_mode_register_r[CMR_LDA +: 2];
  wire [1:0] second_capture_edge = channel_mode_register_r[CMR_LDB +: 2];
  wire [2:0] subsel = channel_mode_register_r[CMR_SUB +: 3];
  wire [1:0] ext_event_source = channel_mode_register_r[CMR_EXT_EVENT_SOURCE +: 2];
  wire [1:0] prof = channel_mode_register_r[CMR_PROF +: 2];
  wire gray_count_enable = wave & stepper_mode_register_r[SMMR_GRAY_COUNT_ENABLE];
  wire b_is_out = wave & (ext_event_source != 2'd0);

  // Bus decode: request taken at the edge where waitrequest is low
  wire wr = AVS_WRITE & ~wait_r;
  wire rd = AVS_READ & ~wait_r;
  wire sel_ccr = AVS_ADDRESS == OFS_CCR;
  wire sel_cmr = AVS_ADDRESS == OFS_CMR;
  wire sel_smmr = AVS_ADDRESS == OFS_SMMR;
  wire sel_rab = AVS_ADDRESS == OFS_RAB;
  wire sel_cca = AVS_ADDRESS == OFS_CCA;
  wire sel_ccb = AVS_ADDRESS == OFS_CCB;
  wire sel_per = AVS_ADDRESS == OFS_PER;
  wire sel_sr = AVS_ADDRESS == OFS_SR;
  wire sel_wpmr = AVS_ADDRESS == OFS_WPMR;
  wire wr_ok = wr & ~write_protect_enable_r;
  wire ccr_wr = wr & sel_ccr & AVS_BYTEENABLE[0];
  wire [31:0] wmerge_cmr = tcwc_merge(channel_mode_register_r,
                                      AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [31:0] wmerge_a = tcwc_merge({16'h0000, capture_compare_a_r},
                                    AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [31:0] wmerge_b = tcwc_merge({16'h0000, capture_compare_b_r},
                                    AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [31:0] wmerge_c = tcwc_merge({16'h0000, period_compare_r},
                                    AVS_WRITEDATA, AVS_BYTEENABLE);

  // Read side effects
  wire rab_pick_a = unread_a_r & (~unread_b_r | a_older_r);
  wire rd_a = rd & (sel_cca | (sel_rab & rab_pick_a));
  wire rd_b = rd & (sel_ccb | (sel_rab & ~rab_pick_a));
  wire rd_sr = rd & sel_sr;

  // Counter stepping and compare matches
  wire cnt_step = CNT_TICK & clk_en_r & clk_run_r & ~trig_pend_r;
  wire cpa_ev = wave & cnt_step &
                (counter_value_r == capture_compare_a_r);
  wire cpb_ev = b_is_out & cnt_step &
                (counter_value_r == capture_compare_b_r);
  wire cpc_ev = cnt_step & (counter_value_r == period_compare_r);

  // External trigger and event selection
  assign e_sel = ~wave ? (channel_mode_register_r[CMR_EXT_TRIGGER_INPUT_SEL] ? e_a : e_b)
               : (ext_event_source == 2'd0) ? e_b
               : (ext_event_source == 2'd1) ? e_x0
               : (ext_event_source == 2'd2) ? e_x1 : e_x2;
  wire ext_hit = tcwc_edge_hit(edge2, e_sel);
  wire ext_event_source_ev = wave & ext_hit;
  wire ext_trig = ~wave ? ext_hit
                : (ext_hit & channel_mode_register_r[CMR_EXT_EVENT_TRIGGER_ENABLE]);
  wire swtrg = ccr_wr & AVS_WRITEDATA[CCR_SWTRG];
  // Period match trigger only in capture with its enable
  wire cap_pc_trig = ~wave & channel_mode_register_r[CMR_CPCTRG] & cpc_ev;
  wire trig_any = swtrg | SYNC_IN | ext_trig | cap_pc_trig;

  // Capture edges and subsampling
  wire ea = ~wave & tcwc_edge_hit(first_capture_edge, e_a);
  wire eb = ~wave & tcwc_edge_hit(second_capture_edge, e_a);
  wire [3:0] sub_mask = (subsel > 3'd4) ? 4'hF
                      : 4'((5'd1 << subsel) - 5'd1);
  wire sub_hit = (ea | eb) & (sub_cnt_r == sub_mask);
  wire load_a = ea & sub_hit & ~b_ok_r;
  wire load_b = eb & sub_hit & b_ok_r;
  wire stop_ev = (wave & cpc_ev & channel_mode_register_r[CMR_PERIOD_MATCH_STOP])
               | (load_b & channel_mode_register_r[CMR_LDBSTOP]);
  wire dis_ev = (wave & cpc_ev & channel_mode_register_r[CMR_PERIOD_MATCH_DISABLE])
              | (load_b & channel_mode_register_r[CMR_LDBDIS]);

  // Read data selection
  always_comb begin
    rd_mux = RST_WORD;
    if (sel_cmr) begin
      rd_mux = channel_mode_register_r;
    end else if (sel_smmr) begin
      rd_mux = {30'h0000_0000, stepper_mode_register_r};
    end else if (sel_rab) begin
      // Oldest unread capture value
      rd_mux = {16'h0000, rab_pick_a ? capture_compare_a_r
                                     : capture_compare_b_r};
    end else if (sel_cca) begin
      rd_mux = {16'h0000, capture_compare_a_r};
    end else if (sel_ccb) begin
      rd_mux = {16'h0000, capture_compare_b_r};
    end else if (sel_per) begin
      rd_mux = {16'h0000, period_compare_r};
    end else if (AVS_ADDRESS == OFS_CV) begin
      rd_mux = {16'h0000, counter_value_r};
    end else if (sel_sr) begin
      rd_mux[SR_COVFS] = covf_r;
      rd_mux[SR_LOAD_OVERRUN_FLAG] = load_overrun_flag_r;
      rd_mux[SR_LDRAS] = ldras_r;
      rd_mux[SR_LDRBS] = ldrbs_r;
      rd_mux[SR_CLKSTA] = clk_en_r;
    end else if (sel_wpmr) begin
      rd_mux[WPMR_WRITE_PROTECT_ENABLE] = write_protect_enable_r;
    end else begin
      // Control register and unmapped offsets read as zero
      rd_mux = RST_WORD;
    end
  end

  // Next counter value for all count profiles
  always_comb begin
    logic [15:0] top;
    top = (wave & prof[1]) ? period_compare_r : CNT_MAX;
    counter_value_nxt = counter_value_r;
    dir_nxt = dir_r;
    covf_set = 1'b0;
    if (CNT_TICK & trig_pend_r) begin
      // Pending trigger lands on this tick
      if (wave & prof[0]) begin
        dir_nxt = (dir_r == TCWC_DIR_UP) ? TCWC_DIR_DN
                                         : TCWC_DIR_UP;
      end else begin
        counter_value_nxt = RST_HALF;
      end
    end else if (cnt_step) begin
      if (~wave | ~prof[0]) begin
        // Up-only: wrap at the top
        covf_set = counter_value_r == CNT_MAX;
        counter_value_nxt = (counter_value_r == top) ? RST_HALF
                          : counter_value_r + CNT_ONE;
      end else if (dir_r == TCWC_DIR_UP) begin
        if (counter_value_r >= top) begin
          dir_nxt = TCWC_DIR_DN;
          counter_value_nxt = counter_value_r - CNT_ONE;
        end else begin
          counter_value_nxt = counter_value_r + CNT_ONE;
        end
      end else begin
        if (counter_value_r == RST_HALF) begin
          dir_nxt = TCWC_DIR_UP;
          counter_value_nxt = CNT_ONE;
        end else begin
          counter_value_nxt = counter_value_r - CNT_ONE;
        end
      end
    end
  end

  // Output controller; later lines win, software trigger highest
  always_comb begin
    logic [1:0] g;
    g = {gray_cnt_r[1], gray_cnt_r[1] ^ gray_cnt_r[0]};
    io_a_nxt = tcwc_act(io_a_r, cpa_ev,
                        channel_mode_register_r[CMR_ACPA +: 2]);
    io_a_nxt = tcwc_act(io_a_nxt, cpc_ev,
                        channel_mode_register_r[CMR_ACPC +: 2]);
    io_a_nxt = tcwc_act(io_a_nxt, ext_event_source_ev,
                        channel_mode_register_r[CMR_AEEVT +: 2]);
    io_a_nxt = tcwc_act(io_a_nxt, swtrg,
                        channel_mode_register_r[CMR_ASWTRG +: 2]);
    io_b_nxt = tcwc_act(io_b_r, cpb_ev,
                        channel_mode_register_r[CMR_BCPB +: 2]);
    io_b_nxt = tcwc_act(io_b_nxt, cpc_ev,
                        channel_mode_register_r[CMR_BCPC +: 2]);
    io_b_nxt = tcwc_act(io_b_nxt, ext_event_source_ev,
                        channel_mode_register_r[CMR_BEEVT +: 2]);
    io_b_nxt = tcwc_act(io_b_nxt, swtrg,
                        channel_mode_register_r[CMR_BSWTRG +: 2]);
    if (~wave) begin
      // Capture mode: lines are inputs only
      io_a_nxt = 1'b0;
      io_b_nxt = 1'b0;
    end else if (gray_count_enable) begin
      io_a_nxt = g[0];
      io_b_nxt = g[1];
    end else if (~b_is_out) begin
      io_b_nxt = 1'b0;
    end
  end

  // Pin synchronisers; stage 1 feeds stage 2 only
  always_ff @(posedge CORE_CLK) begin
    pin_s1_r <= {EXTERNAL_CLOCK_2, EXTERNAL_CLOCK_1, EXTERNAL_CLOCK_0,
                 CHANNEL_IO_B_IN, CHANNEL_IO_A_IN};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  // Bus slave: one wait state, data registered for the ready edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wait_r <= 1'b1;
      rdata_r <= RST_WORD;
    end else begin
      wait_r <= ~((AVS_READ | AVS_WRITE) & wait_r);
      if (AVS_READ & wait_r) rdata_r <= rd_mux;
    end
  end

  // Configuration registers, all but the protection register blocked while protected
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      channel_mode_register_r <= RST_WORD;
      stepper_mode_register_r <= 2'b00;
      write_protect_enable_r <= 1'b0;
      period_compare_r <= RST_HALF;
    end else begin
      if (wr_ok & sel_cmr) channel_mode_register_r <= wmerge_cmr;
      if (wr_ok & sel_smmr & AVS_BYTEENABLE[0]) begin
        stepper_mode_register_r <= AVS_WRITEDATA[1:0];
      end
      if (wr_ok & sel_per) period_compare_r <= wmerge_c[15:0];
      // Protection register needs channel 0's clock running
      if (wr & sel_wpmr & CH0_CLK_ON & AVS_BYTEENABLE[0]) begin
        write_protect_enable_r <= AVS_WRITEDATA[WPMR_WRITE_PROTECT_ENABLE];
      end
    end
  end

  // Capture/compare A and B: captured, or written in waveform mode
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      capture_compare_a_r <= RST_HALF;
      capture_compare_b_r <= RST_HALF;
    end else begin
      if (load_a) begin
        capture_compare_a_r <= counter_value_r;
      end else if (wr_ok & wave & sel_cca) begin
        capture_compare_a_r <= wmerge_a[15:0];
      end
      if (load_b) begin
        capture_compare_b_r <= counter_value_r;
      end else if (wr_ok & wave & sel_ccb) begin
        capture_compare_b_r <= wmerge_b[15:0];
      end
    end
  end

  // Load ordering, unread tracking and subsample count
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sub_cnt_r <= SUB_ZERO;
      b_ok_r <= 1'b0;
      unread_a_r <= 1'b0;
      unread_b_r <= 1'b0;
      a_older_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      if (trig_any) sub_cnt_r <= SUB_ZERO;
      else if (ea | eb) sub_cnt_r <= sub_hit ? SUB_ZERO
                                             : sub_cnt_r + SUB_ONE;
      // A load arms B; B load re-arms A; a trigger restarts at A
      if (load_a) b_ok_r <= 1'b1;
      else if (load_b | trig_any) b_ok_r <= 1'b0;
      // A new load beats a read in the same cycle
      unread_a_r <= load_a | (unread_a_r & ~rd_a);
      unread_b_r <= load_b | (unread_b_r & ~rd_b);
      if (load_a) a_older_r <= ~unread_b_r;
      else if (load_b) a_older_r <= unread_a_r;
      // Request only toward memory: a read of the combined value
      dma_r <= load_a | load_b;
    end
  end

  // Status flags; hardware set wins over the clearing read
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      covf_r <= 1'b0;
      load_overrun_flag_r <= 1'b0;
      ldras_r <= 1'b0;
      ldrbs_r <= 1'b0;
    end else begin
      covf_r <= covf_set | (covf_r & ~rd_sr);
      load_overrun_flag_r <= (load_a & unread_a_r) | (load_b & unread_b_r)
                           | (load_overrun_flag_r & ~rd_sr);
      ldras_r <= load_a | (ldras_r & ~rd_sr);
      ldrbs_r <= load_b | (ldrbs_r & ~rd_sr);
    end
  end

  // Counter, direction and clock enable/start control
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      counter_value_r <= RST_HALF;
      dir_r <= TCWC_DIR_UP;
      clk_en_r <= 1'b0;
      clk_run_r <= 1'b0;
      trig_pend_r <= 1'b0;
    end else begin
      counter_value_r <= counter_value_nxt;
      dir_r <= dir_nxt;
      // Trigger waits for the next counter tick
      if (trig_any) trig_pend_r <= 1'b1;
      else if (CNT_TICK) trig_pend_r <= 1'b0;
      if (CNT_TICK & trig_pend_r & clk_en_r) clk_run_r <= 1'b1;
      else if (stop_ev) clk_run_r <= 1'b0;
      // Software disable beats enable; both beat hardware disable
      if (ccr_wr & AVS_WRITEDATA[CCR_CLKDIS]) clk_en_r <= 1'b0;
      else if (ccr_wr & AVS_WRITEDATA[CCR_CLKEN]) clk_en_r <= 1'b1;
      else if (dis_ev) clk_en_r <= 1'b0;
    end
  end

  // Waveform lines and stepper phase
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      gray_cnt_r <= 2'b00;
      io_a_r <= 1'b0;
      io_b_r <= 1'b0;
      io_a_oe_r <= 1'b0;
      io_b_oe_r <= 1'b0;
    end else begin
      // One Gray step per period match
      if (gray_count_enable & cpc_ev) begin
        gray_cnt_r <= stepper_mode_register_r[SMMR_DOWN]
                    ? gray_cnt_r - GRAY_ONE : gray_cnt_r + GRAY_ONE;
      end
      io_a_r <= io_a_nxt;
      io_b_r <= io_b_nxt;
      io_a_oe_r <= wave;
      io_b_oe_r <= b_is_out;
    end
  end

  // Ports straight from flip-flops
  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign CHANNEL_IO_A_OUT = io_a_r;
  assign CHANNEL_IO_A_OE = io_a_oe_r;
  assign CHANNEL_IO_B_OUT = io_b_r;
  assign CHANNEL_IO_B_OE = io_b_oe_r;
  assign DMA_REQ = dma_r;
endmodule // tcwc_channel
`default_nettype wire

// >>> rtl/tcwc_pkg.sv
// Constants, types and helpers for the timer capture/waveform channel
package tcwc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CCR = 8'h00;
  localparam logic [7:0] OFS_CMR = 8'h04;
  localparam logic [7:0] OFS_SMMR = 8'h08;
  localparam logic [7:0] OFS_RAB = 8'h0C;
  localparam logic [7:0] OFS_CV = 8'h10;
  localparam logic [7:0] OFS_CCA = 8'h14;
  localparam logic [7:0] OFS_CCB = 8'h18;
  localparam logic [7:0] OFS_PER = 8'h1C;
  localparam logic [7:0] OFS_SR = 8'h20;
  localparam logic [7:0] OFS_WPMR = 8'hE4;
  // Command bits of the control register
  localparam int CCR_CLKEN = 0;
  localparam int CCR_CLKDIS = 1;
  localparam int CCR_SWTRG = 2;
  // Mode register fields, shared positions
  localparam int CMR_WAVE = 15;
  localparam int CMR_EDGE2 = 8;
  // Capture layout
  localparam int CMR_LDBSTOP = 6;
  localparam int CMR_LDBDIS = 7;
  localparam int CMR_EXT_TRIGGER_INPUT_SEL = 10;
  localparam int CMR_CPCTRG = 14;
  localparam int CMR_LDA = 16;
  localparam int CMR_LDB = 18;
  localparam int CMR_SUB = 20;
  // Waveform layout
  localparam int CMR_PERIOD_MATCH_STOP = 6;
  localparam int CMR_PERIOD_MATCH_DISABLE = 7;
  localparam int CMR_EXT_EVENT_SOURCE = 10;
  localparam int CMR_EXT_EVENT_TRIGGER_ENABLE = 12;
  localparam int CMR_PROF = 13;
  localparam int CMR_ACPA = 16;
  localparam int CMR_ACPC = 18;
  localparam int CMR_AEEVT = 20;
  localparam int CMR_ASWTRG = 22;
  localparam int CMR_BCPB = 24;
  localparam int CMR_BCPC = 26;
  localparam int CMR_BEEVT = 28;
  localparam int CMR_BSWTRG = 30;
  // Stepper and protection bits
  localparam int SMMR_GRAY_COUNT_ENABLE = 0;
  localparam int SMMR_DOWN = 1;
  localparam int WPMR_WRITE_PROTECT_ENABLE = 0;
  // Status bits
  localparam int SR_COVFS = 0;
  localparam int SR_LOAD_OVERRUN_FLAG = 1;
  localparam int SR_LDRAS = 5;
  localparam int SR_LDRBS = 6;
  localparam int SR_CLKSTA = 16;
  // Reset values and limits
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] SUB_ZERO = 4'h0;
  localparam logic [3:0] SUB_ONE = 4'h1;
  localparam logic [1:0] GRAY_ONE = 2'h1;

  // Counting direction, one-hot
  typedef enum logic [1:0] {
    TCWC_DIR_UP = 2'b01,
    TCWC_DIR_DN = 2'b10
  } tcwc_dir_t;

  // Edge pair of one synchronised line
  typedef struct packed {
    logic rise;
    logic fall;
  } tcwc_edge_t;

  // Edge field: 1 rising, 2 falling, 3 both, 0 none
  function automatic logic tcwc_edge_hit(input logic [1:0] sel,
                                         input tcwc_edge_t e);
    tcwc_edge_hit = (sel[0] & e.rise) | (sel[1] & e.fall);
  endfunction

  // Output action: 1 set, 2 clear, 3 toggle, 0 hold
  function automatic logic tcwc_act(input logic cur, input logic ev,
                                    input logic [1:0] code);
    tcwc_act = cur;
    if (ev) begin
      case (code)
        2'd1: tcwc_act = 1'b1;
        2'd2: tcwc_act = 1'b0;
        2'd3: tcwc_act = ~cur;
        default: tcwc_act = cur;
      endcase
    end
  endfunction

  // Byte-enable merge of a write into an old word
  function automatic logic [31:0] tcwc_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    tcwc_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) tcwc_merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction
endpackage

// >>> sim/tcwc_monitor.sv
// Port checker for the timer channel, bound to the top module
`timescale 1ns/1ns
`default_nettype none
module tcwc_monitor (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic CHANNEL_IO_A_OE,
  input wire logic CHANNEL_IO_B_OE,
  input wire logic DMA_REQ
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Reset parks the bus and releases both lines
  property p_rst;
    disable iff (1'b0) RESET |=> AVS_WAITREQUEST && !DMA_REQ &&
      !CHANNEL_IO_A_OE && !CHANNEL_IO_B_OE;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  // A fresh request is answered one cycle later
  property p_ack;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_ack: assert property (p_ack)
    else $error("request not answered");
  // The answer lasts exactly one cycle
  property p_ack_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("answer too long");
  // No answer without a request
  property p_idle;
    !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  // Read data moves only because of a read
  property p_rdata;
    !$stable(AVS_READDATA) |-> $past(AVS_READ);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data moved");
  // Holes in the map read as zero
  property p_hole;
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS > 8'h20 &&
      AVS_ADDRESS != 8'hE4 |=> AVS_READDATA == 32'h0000_0000;
  endproperty
  a_hole: assert property (p_hole)
    else $error("hole read not zero");
  // Capture loads only happen with line A as input
  property p_dma;
    DMA_REQ |-> !CHANNEL_IO_A_OE;
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma request in waveform");
  // Line B may only drive when line A drives
  property p_oe;
    CHANNEL_IO_B_OE |-> CHANNEL_IO_A_OE;
  endproperty
  a_oe: assert property (p_oe)
    else $error("line B driven alone");
endmodule // tcwc_monitor
bind tcwc_channel tcwc_monitor tcwc_monitor_i (.CORE_CLK, .RESET,
  .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
  .CHANNEL_IO_A_OE, .CHANNEL_IO_B_OE, .DMA_REQ);
`default_nettype wire

// >>> sim/tcwc_line_model.sv
// Far-side drivers of the two channel lines
`timescale 1ns/1ns
`default_nettype none
module tcwc_line_model (
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  output logic a_pin,
  output logic b_pin
);
  // Far side yields a line while the channel drives it
  assign a_pin = a_oe ? a_out : a_lvl;
  assign b_pin = b_oe ? b_out : b_lvl;
endmodule // tcwc_line_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ns
`default_nettype none
module tb_top import tcwc_pkg::*;;
  logic clk = 0, rst = 1, rd = 0, wr = 0, tick = 0, sync = 0, ch0 = 1;
  logic a_lvl = 0, b_lvl = 0, ao, aoe, bo, boe, pa, pb, wt, dma;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, q;
  int num_errors = 0, comparisons = 0, cyc = 0, dmac = 0, d0 = 0;
  // Reset-value sweep, one hole at the end
  logic [7:0] ofs [10] = '{OFS_CMR, OFS_SMMR, OFS_RAB, OFS_CV, OFS_CCA,
    OFS_CCB, OFS_PER, OFS_SR, OFS_WPMR, 8'h40};
  // 20 MHz clock
  always #25 clk = ~clk;
  tcwc_channel tcwc_channel_i (.CORE_CLK(clk), .RESET(rst),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
    .CNT_TICK(tick), .SYNC_IN(sync), .CH0_CLK_ON(ch0),
    .CHANNEL_IO_A_IN(pa), .CHANNEL_IO_A_OUT(ao), .CHANNEL_IO_A_OE(aoe),
    .CHANNEL_IO_B_IN(pb), .CHANNEL_IO_B_OUT(bo), .CHANNEL_IO_B_OE(boe),
    .EXTERNAL_CLOCK_0(1'b0), .EXTERNAL_CLOCK_1(1'b0),
    .EXTERNAL_CLOCK_2(1'b0), .DMA_REQ(dma));
  tcwc_line_model tcwc_line_model_i (.a_lvl(a_lvl), .b_lvl(b_lvl),
    .a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe), .a_pin(pa), .b_pin(pb));
  // Verdict and end of run
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] s, e, input string n);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string n);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, e, n);
  endtask
  // Counter ticks, spaced so none is back to back
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  // High pulse on line A or B, long enough for the synchroniser
  task automatic pin(input logic sel);
    @(posedge clk);
    if (sel) b_lvl <= 1'b1;
    else a_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    a_lvl <= 1'b0;
    b_lvl <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Timeout and DMA pulse count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma === 1'b1) dmac <= dmac + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (ofs[i]) rchk(ofs[i], 32'h0000_0000, "reset");
    $display("test reset done");
    // Capture: both loads on A rising, trigger on B rising
    acc(1'b1, OFS_CMR, 32'h0005_0100);
    acc(1'b1, OFS_CCR, 32'h0000_0001);
    pin(1'b1);
    tk(4);
    rchk(OFS_CV, 32'h0000_0003, "cv");
    pin(1'b0);
    tk(1);
    pin(1'b0);
    tk(1);
    pin(1'b0);
    rchk(OFS_SR, 32'h0001_0062, "sr");
    rchk(OFS_RAB, 32'h0000_0004, "rab");
    rchk(OFS_RAB, 32'h0000_0005, "rab");
    rchk(OFS_SR, 32'h0001_0000, "sr");
    chk(dmac, 32'h0000_0003, "dma");
    for (int s = 1; s < 5; s++) begin
      acc(1'b1, OFS_CMR, 32'h0005_0100 | (s << 20));
      // Count from a base so only the always block writes the counter
      d0 = dmac;
      repeat (16) pin(1'b0);
      chk(dmac - d0, 32'(16 >> s), "sub");
    end
    $display("test capture done");
    // Waveform, profile 10, C toggles A, event on ext clock 0
    acc(1'b1, OFS_PER, 32'h0000_0003);
    acc(1'b1, OFS_CMR, 32'h000C_C400);
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    tk(7);
    rchk(OFS_CV, 32'h0000_0002, "cv");
    chk({29'h0, aoe, boe, ao}, 32'h0000_0007, "lines");
    acc(1'b1, OFS_SMMR, 32'h0000_0001);
    tk(6);
    // Lines follow the stepper one clock after the step lands
    repeat (2) @(posedge clk);
    chk({30'h0, bo, ao}, 32'h0000_0003, "gray");
    acc(1'b1, OFS_SMMR, 32'h0000_0003);
    tk(4);
    repeat (2) @(posedge clk);
    chk({30'h0, bo, ao}, 32'h0000_0001, "gray");
    acc(1'b1, OFS_SMMR, 32'h0000_0000);
    // Profile 11: up to C, back down, a trigger reverses
    acc(1'b1, OFS_CMR, 32'h0000_E000);
    tk(5);
    rchk(OFS_CV, 32'h0000_0001, "cv");
    acc(1'b1, OFS_CCR, 32'h0000_0004);
    tk(2);
    rchk(OFS_CV, 32'h0000_0002, "cv");
    // Profile 00 with line B as event input
    acc(1'b1, OFS_CMR, 32'h0000_8000);
    acc(1'b1, OFS_CCR, 32'h0000_0004);
    tk(6);
    rchk(OFS_CV, 32'h0000_0005, "cv");
    chk({30'h0, aoe, boe}, 32'h0000_0002, "oe");
    // Rising edge on line B, enabled as trigger, clears the count
    acc(1'b1, OFS_CMR, 32'h0000_9100);
    pin(1'b1);
    tk(1);
    rchk(OFS_CV, 32'h0000_0000, "cv");
    acc(1'b1, OFS_CMR, 32'h0000_8080);
    acc(1'b0, OFS_SR, 32'h0000_0000);
    acc(1'b1, OFS_CCR, 32'h0000_0004);
    tk(5);
    rchk(OFS_SR, 32'h0000_0000, "sr");
    $display("test waveform done");
    // Write protection, and its register needing channel 0 clock
    acc(1'b1, OFS_WPMR, 32'h0000_0001);
    acc(1'b1, OFS_PER, 32'h0000_1234);
    rchk(OFS_PER, 32'h0000_0003, "per");
    ch0 <= 1'b0;
    acc(1'b1, OFS_WPMR, 32'h0000_0000);
    rchk(OFS_WPMR, 32'h0000_0001, "wpmr");
    ch0 <= 1'b1;
    $display("test protect done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
